// [hw/dco_command_handler.sv]
// Configuration overlay command handler: restore, freeze, identify, set
`timescale 1ns/1ps
module dco_command_handler
	import dco_pkg::*;
#(
	parameter logic [MDMA_W-1:0] FACT_MDMA = 3'h7,
	parameter logic [UDMA_W-1:0] FACT_UDMA = 6'h3f,
	parameter logic [FEAT_W-1:0] FACT_FEAT = 9'h1ff,
	parameter logic [LBA_W-1:0] FACT_MAXLBA = 64'h0000_0000_0fff_ffff
) (
	input wire logic clk, // 200 MHz clock
	input wire logic srst, // Sync reset, host or soft
	input wire logic powerOnRst, // Power-on reset only
	input wire logic cmdStrobe, // Command write pulse
	input wire logic [7:0] cmdCode, // Command opcode
	input wire logic [7:0] subcommandSelector, // Subcommand code
	input wire logic [15:0] setData, // Set overlay word in
	input wire logic setValid, // Set word offered
	output logic setReady, // Set word taken
	output logic [15:0] pioData, // Identify word out
	output logic pioValid, // Identify word offered
	input wire logic pioReady, // Host takes word
	output logic busy, // Busy status
	output logic dataRequest, // Data-request status
	output logic deviceReady, // Device-ready status
	output logic errorFlag, // Error status
	output logic commandAbortedBit, // Abort bit of error reg
	output logic frozen, // Freeze-lock state
	output logic [MDMA_W-1:0] liveMdma, // Identify word 63 bits
	output logic [UDMA_W-1:0] liveUdma, // Identify word 88 bits
	output logic [FEAT_W-1:0] liveFeat, // Live feature bits
	output logic [LBA_W-1:0] liveMaxLba // Live native max
);
	dco_state_t state;
	logic [7:0] wordIdx;
	logic [7:0] sum;
	logic modified;
	logic [MDMA_W-1:0] setMdma;
	logic [UDMA_W-1:0] setUdma;
	logic [FEAT_W-1:0] setFeat;
	logic [LBA_W-1:0] setLba;
	logic [15:0] word;
	logic [15:0] bufIn;
	logic bufValid;
	logic bufReady;
	logic take;
	logic isCmd;

	// Byte sum of one word, used for checksum accumulation
	function automatic logic [7:0] byteSum(input logic [15:0] w);
		return w[7:0] + w[15:8];
	endfunction

	// Overlay word, always factory content, never the live set
	function automatic logic [15:0] overlayWord(input logic [7:0] i);
		logic [15:0] w;
		w = 16'h0000;
		if (i == W_REV)
			w = REVISION;
		else if (i == W_MDMA)
			w = {13'h0000, FACT_MDMA};
		else if (i == W_UDMA)
			w = {10'h000, FACT_UDMA};
		else if (i >= W_LBA0 && i <= W_LBA3)
			w = FACT_MAXLBA[16*(i-W_LBA0) +: 16];
		else if (i == W_FEAT)
			w = {7'h00, FACT_FEAT};
		return w;
	endfunction

	assign isCmd = cmdStrobe && cmdCode == CMD_OVERLAY && state == DCO_IDLE;
	assign take = bufValid && bufReady;
	assign setReady = (state == DCO_SETIN);

	// ----------------------------------------
	// Freeze lock: only power-on clears it
	// ----------------------------------------
	// Hardware and soft resets arrive on srst and do not touch this flop
	always_ff @(posedge clk) begin
		if (powerOnRst)
			frozen <= 1'b0;
		else if (isCmd && !frozen && subcommandSelector == SUB_FREEZE)
			frozen <= 1'b1;
	end

	// ----------------------------------------
	// Live capabilities seen by identify device
	// ----------------------------------------
	// Settings persist over soft resets, like the freeze lock
	always_ff @(posedge clk) begin
		if (powerOnRst) begin
			modified <= 1'b0;
		end else if (isCmd && !frozen && subcommandSelector == SUB_RESTORE) begin
			modified <= 1'b0;
		end else if (state == DCO_SETIN && setValid && wordIdx == W_LAST) begin
			modified <= 1'b1;
		end
	end

	// Set words are captured; mode and feature bits are masked to factory, max LBA words are taken as written
	always_ff @(posedge clk) begin
		if (state == DCO_SETIN && setValid) begin
			if (wordIdx == W_MDMA)
				setMdma <= setData[MDMA_W-1:0] & FACT_MDMA;
			if (wordIdx == W_UDMA)
				setUdma <= setData[UDMA_W-1:0] & FACT_UDMA;
			if (wordIdx == W_FEAT)
				setFeat <= setData[FEAT_W-1:0] & FACT_FEAT;
			if (wordIdx >= W_LBA0 && wordIdx <= W_LBA3)
				setLba[16*(wordIdx-W_LBA0) +: 16] <= setData;
		end
	end

	// Factory values after restore, reduced ones after set
	assign liveMdma = modified ? setMdma : FACT_MDMA;
	assign liveUdma = modified ? setUdma : FACT_UDMA;
	assign liveFeat = modified ? setFeat : FACT_FEAT;
	assign liveMaxLba = modified ? setLba : FACT_MAXLBA;

	// ----------------------------------------
	// Sequencer and status
	// ----------------------------------------
	// Task-file registers are inputs here and never written back
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= DCO_IDLE;
			wordIdx <= 8'h00;
			sum <= 8'h00;
			busy <= 1'b0;
			errorFlag <= 1'b0;
			commandAbortedBit <= 1'b0;
		end else begin
			case (state)
			DCO_IDLE: begin
				if (isCmd) begin
					wordIdx <= 8'h00;
					sum <= 8'h00;
					errorFlag <= 1'b0;
					commandAbortedBit <= 1'b0;
					if (frozen || subcommandSelector < SUB_RESTORE ||
						subcommandSelector > SUB_SET ||
						(subcommandSelector == SUB_SET && modified)) begin
						errorFlag <= 1'b1;
						commandAbortedBit <= 1'b1;
					end else if (subcommandSelector == SUB_IDENTIFY) begin
						busy <= 1'b1;
						state <= DCO_SEND;
					end else if (subcommandSelector == SUB_SET) begin
						state <= DCO_SETIN;
					end
				end
			end
			DCO_SETIN: begin
				if (setValid) begin
					wordIdx <= wordIdx + 8'h01;
					if (wordIdx == W_LAST)
						state <= DCO_IDLE;
				end
			end
			DCO_SEND: begin
				busy <= 1'b0;
				if (take) begin
					sum <= sum + byteSum(bufIn);
					wordIdx <= wordIdx + 8'h01;
					if (wordIdx == W_LAST)
						state <= DCO_DONE;
				end
			end
			DCO_DONE: state <= DCO_IDLE;
			default: state <= DCO_IDLE;
			endcase
		end
	end

	// Word 255 closes the structure so all 512 bytes sum to zero
	always_comb begin
		word = overlayWord(wordIdx);
		if (wordIdx == W_LAST)
			word = {8'h00 - sum - SIGNATURE, SIGNATURE};
	end
	assign bufIn = word;
	assign bufValid = (state == DCO_SEND) && !busy;

	// Two-entry buffer so a host stall loses no word
	dco_skid_buffer #(.WIDTH(16)) uBuf (
		.clk(clk),
		.srst(srst),
		.inData(bufIn),
		.inValid(bufValid),
		.inReady(bufReady),
		.outData(pioData),
		.outValid(pioValid),
		.outReady(pioReady)
	);

	assign dataRequest = pioValid;
	assign deviceReady = 1'b1;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_frozen_abort: assert property (@(posedge clk) disable iff (srst)
		isCmd && frozen |=> commandAbortedBit && errorFlag && state == DCO_IDLE)
		else $error("frozen subcommand not aborted");
	chk_freeze_sets: assert property (@(posedge clk)
		disable iff (powerOnRst)
		isCmd && !frozen && subcommandSelector == SUB_FREEZE |=> frozen)
		else $error("freeze lock not taken");
	// Power-on clears the lock at its edge, so the drop shows one cycle on
	chk_freeze_hold: assert property (@(posedge clk)
		$past(frozen) && !$past(powerOnRst) |-> frozen)
		else $error("freeze lock lost without power-down");
	chk_restore_live: assert property (@(posedge clk)
		disable iff (powerOnRst)
		isCmd && !frozen && subcommandSelector == SUB_RESTORE |=>
		liveMdma == FACT_MDMA && liveMaxLba == FACT_MAXLBA)
		else $error("restore left modified values");
	// Identify start: sequencer enters send, then offers word 0
	sequence identify_start;
		state == DCO_SEND ##1 bufValid;
	endsequence
	chk_identify_go: assert property (@(posedge clk) disable iff (srst)
		isCmd && !frozen && subcommandSelector == SUB_IDENTIFY |=>
		identify_start)
		else $error("identify did not start");
	chk_first_word: assert property (@(posedge clk) disable iff (srst)
		bufValid && wordIdx == W_REV |-> bufIn == REVISION)
		else $error("revision word wrong");
	chk_mdma_word: assert property (@(posedge clk) disable iff (srst)
		bufValid && wordIdx == W_MDMA |-> bufIn[15:3] == 13'h0000)
		else $error("multiword DMA reserved bits set");
	chk_reserved_zero: assert property (@(posedge clk)
		disable iff (srst)
		bufValid && wordIdx > W_FEAT && wordIdx != W_LAST |->
		bufIn == 16'h0000)
		else $error("reserved word not zero");
	chk_checksum: assert property (@(posedge clk) disable iff (srst)
		take && wordIdx == W_LAST |-> byteSum(bufIn) + sum == 8'h00)
		else $error("checksum does not close");
	chk_abort_status: assert property (@(posedge clk) disable iff (srst)
		commandAbortedBit |-> errorFlag && !dataRequest && deviceReady)
		else $error("abort status inconsistent");
endmodule // dco_command_handler

// [hw/dco_pkg.sv]
// Package: constants for the configuration overlay command handler
package dco_pkg;
	// ----------------------------------------
	// Command and subcommand codes
	// ----------------------------------------
	localparam logic [7:0] CMD_OVERLAY = 8'hb1;
	localparam logic [7:0] SUB_RESTORE = 8'hc0;
	localparam logic [7:0] SUB_FREEZE = 8'hc1;
	localparam logic [7:0] SUB_IDENTIFY = 8'hc2;
	localparam logic [7:0] SUB_SET = 8'hc3;
	// ----------------------------------------
	// Structure layout
	// ----------------------------------------
	localparam int WORDS = 256;
	localparam logic [7:0] W_REV = 8'h00;
	localparam logic [7:0] W_MDMA = 8'h01;
	localparam logic [7:0] W_UDMA = 8'h02;
	localparam logic [7:0] W_LBA0 = 8'h03;
	localparam logic [7:0] W_LBA3 = 8'h06;
	localparam logic [7:0] W_FEAT = 8'h07;
	localparam logic [7:0] W_LAST = 8'hff;
	localparam logic [15:0] REVISION = 16'h0001;
	localparam logic [7:0] SIGNATURE = 8'ha5;
	localparam int MDMA_W = 3;
	localparam int UDMA_W = 6;
	localparam int FEAT_W = 9;
	localparam int LBA_W = 64;
	// ----------------------------------------
	// Handler states
	// ----------------------------------------
	typedef enum logic [2:0] {
		DCO_IDLE, DCO_SETIN, DCO_SEND, DCO_DONE
	} dco_state_t;
endpackage

// [hw/dco_skid_buffer.sv]
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module dco_skid_buffer #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // Clock
	input wire logic srst, // Sync reset
	input wire logic [WIDTH-1:0] inData, // Word in
	input wire logic inValid, // Word offered
	output logic inReady, // Room free
	output logic [WIDTH-1:0] outData, // Word out
	output logic outValid, // Word held
	input wire logic outReady // Taker ready
);
	logic [WIDTH-1:0] mem [2];
	logic wrPtr;
	logic rdPtr;
	logic [1:0] count;

	// Handshakes from occupancy only
	assign inReady = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData = mem[rdPtr];

	// Storage and pointers
	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (inValid && inReady) begin
				mem[wrPtr] <= inData;
				wrPtr <= ~wrPtr;
			end
			if (outValid && outReady)
				rdPtr <= ~rdPtr;
			count <= count + 2'(inValid && inReady) - 2'(outValid && outReady);
		end
	end
endmodule // dco_skid_buffer

// [testbench/dco_host_model.sv]
// Host model: takes identify words off the PIO data-in side
`timescale 1ns/1ps
module dco_host_model (
	input wire logic clk, // Clock
	input wire logic clear, // Restart word capture
	input wire logic stall, // Slow taker mode
	input wire logic [15:0] pioData, // Word from device
	input wire logic pioValid, // Word offered
	output logic pioReady, // Host takes word
	output int wordCount // Words taken so far
);
	logic [15:0] words [256];
	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// Stall toggles ready so the buffer must hold a word across gaps
	always_ff @(posedge clk) begin
		if (clear) begin
			pioReady <= 1'b0;
			wordCount <= 0;
		end else begin
			pioReady <= stall ? ~pioReady : 1'b1;
			if (pioValid && pioReady) begin
				words[wordCount[7:0]] <= pioData;
				wordCount <= wordCount + 1;
			end
		end
	end
endmodule // dco_host_model

// [testbench/dco_command_handler_bench.sv]
// Testbench for the configuration overlay command handler
`timescale 1ns/1ps
module dco_command_handler_bench;
	import dco_pkg::*;
	logic clk, srst, powerOnRst, cmdStrobe, setValid, setReady, pioValid;
	logic pioReady, busy, dataRequest, deviceReady, errorFlag;
	logic commandAbortedBit, frozen, clear, stall;
	logic [7:0] cmdCode, subcommandSelector;
	logic [15:0] setData, pioData;
	logic [2:0] liveMdma;
	logic [5:0] liveUdma;
	logic [8:0] liveFeat;
	logic [63:0] liveMaxLba;
	int wordCount, nMismatch, checksDone;
	logic [15:0] expWords [8] = '{16'h0001, 16'h0003, 16'h001f, 16'h6789,
		16'h2345, 16'h0001, 16'h0000, 16'h00f5};
	logic [7:0] subs [4] = '{SUB_SET, SUB_FREEZE, SUB_IDENTIFY, SUB_RESTORE};
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin nMismatch++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
	// ----------------------------------------
	// Devices
	// ----------------------------------------
	dco_command_handler #(.FACT_MDMA(3'h3), .FACT_UDMA(6'h1f),
		.FACT_FEAT(9'h0f5), .FACT_MAXLBA(64'h0000_0001_2345_6789))
		i_dco_command_handler (.clk(clk), .srst(srst),
		.powerOnRst(powerOnRst), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
		.subcommandSelector(subcommandSelector), .setData(setData),
		.setValid(setValid), .setReady(setReady), .pioData(pioData),
		.pioValid(pioValid), .pioReady(pioReady), .busy(busy),
		.dataRequest(dataRequest), .deviceReady(deviceReady),
		.errorFlag(errorFlag), .commandAbortedBit(commandAbortedBit),
		.frozen(frozen), .liveMdma(liveMdma), .liveUdma(liveUdma),
		.liveFeat(liveFeat), .liveMaxLba(liveMaxLba));
	dco_host_model i_dco_host_model (.clk(clk), .clear(clear), .stall(stall),
		.pioData(pioData), .pioValid(pioValid), .pioReady(pioReady),
		.wordCount(wordCount));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One command write, strobe held for a single edge
	task automatic issue(input logic [7:0] op, input logic [7:0] sel);
		@(posedge clk);
		cmdStrobe <= 1'b1;
		cmdCode <= op;
		subcommandSelector <= sel;
		@(posedge clk);
		cmdStrobe <= 1'b0;
	endtask
	// Error bits update at the taking edge; read two edges after it
	task automatic chk_status(input logic e);
		repeat (2) @(posedge clk);
		`CHK(errorFlag, e)
		`CHK(commandAbortedBit, e)
		`CHK(deviceReady, 1'b1)
		`CHK({busy, dataRequest}, 2'b00)
	endtask
	// Reduced overlay: fewer modes, features and a smaller max address
	task automatic send_set;
		int n;
		issue(8'hb1, SUB_SET);
		for (int i = 0; i < 256; i++) begin
			case (i)
				0, 1: setData <= 16'h0001;
				2: setData <= 16'h0003;
				3: setData <= 16'h0789;
				7: setData <= 16'h00f0;
				255: setData <= 16'h00a5;
				default: setData <= 16'h0000;
			endcase
			setValid <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!setReady && n < 50);
			if (n >= 50) begin
				nMismatch++;
				report_and_stop();
			end
		end
		setValid <= 1'b0;
	endtask
	// Read the whole overlay structure and check every word
	task automatic run_ident(input logic slow);
		logic [7:0] sum;
		int n;
		stall <= slow;
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		issue(8'hb1, SUB_IDENTIFY);
		@(posedge clk);
		`CHK(busy, 1'b1)
		repeat (2) @(posedge clk);
		`CHK(dataRequest, 1'b1)
		n = 0;
		while (wordCount < 256 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			nMismatch++;
			report_and_stop();
		end
		repeat (6) @(posedge clk);
		`CHK(wordCount, 256)
		`CHK(errorFlag, 1'b0)
		for (int i = 0; i < 8; i++)
			`CHK(i_dco_host_model.words[i], expWords[i])
		for (int i = 8; i < 255; i++)
			`CHK(i_dco_host_model.words[i], 16'h0000)
		`CHK(i_dco_host_model.words[255][7:0], 8'ha5)
		sum = 8'h00;
		for (int i = 0; i < 256; i++)
			sum += i_dco_host_model.words[i][7:0] + i_dco_host_model.words[i][15:8];
		`CHK(sum, 8'h00)
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{srst, powerOnRst} = 2'b11;
		{cmdStrobe, setValid, clear, stall} = 4'h0;
		cmdCode = 8'h00;
		subcommandSelector = 8'h00;
		setData = 16'h0000;
		nMismatch = 0;
		checksDone = 0;
		repeat (3) @(posedge clk);
		{srst, powerOnRst} <= 2'b00;
		run_ident(1'b0);
		issue(8'hb1, 8'h55);
		chk_status(1'b1);
		issue(8'hec, SUB_FREEZE);
		chk_status(1'b1);
		`CHK(frozen, 1'b0)
		send_set();
		chk_status(1'b0);
		`CHK({liveMdma, liveUdma, liveFeat}, {3'h1, 6'h03, 9'h0f0})
		`CHK(liveMaxLba, 64'h789)
		run_ident(1'b1);
		issue(8'hb1, SUB_SET);
		chk_status(1'b1);
		issue(8'hb1, SUB_RESTORE);
		chk_status(1'b0);
		`CHK({liveMdma, liveUdma, liveFeat}, {3'h3, 6'h1f, 9'h0f5})
		`CHK(liveMaxLba, 64'h0000_0001_2345_6789)
		issue(8'hb1, SUB_FREEZE);
		chk_status(1'b0);
		`CHK(frozen, 1'b1)
		// Every subcommand refused once locked
		foreach (subs[i]) begin
			issue(8'hb1, subs[i]);
			chk_status(1'b1);
		end
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		issue(8'hb1, SUB_IDENTIFY);
		chk_status(1'b1);
		`CHK(frozen, 1'b1)
		powerOnRst <= 1'b1;
		@(posedge clk);
		powerOnRst <= 1'b0;
		@(posedge clk);
		`CHK(frozen, 1'b0)
		run_ident(1'b0);
		report_and_stop();
	end
endmodule // dco_command_handler_bench
